// ---- rtl/aspm_pkg.sv ----
// shared types and constants for link power state control
package aspm_pkg;

  // ****************************************************************
  // clock and persistence intervals
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int L0S_PERSIST_NS = 7000;
  localparam int L1_PERSIST_NS = 1000000;
  // least times round up
  localparam int L0S_PERSIST_CYC = (L0S_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int L1_PERSIST_CYC = (L1_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // link control enable field
  // ****************************************************************
  localparam int ASPM_W = 2;
  localparam int ASPM_L0S_BIT = 0;
  localparam int ASPM_L1_BIT = 1;

  // ****************************************************************
  // training state codes and link power states
  // ****************************************************************
  typedef enum logic [3:0] {
    LTSSM_DETECT,
    LTSSM_POLLING,
    LTSSM_CONFIG,
    LTSSM_L0,
    LTSSM_RECOVERY,
    LTSSM_DISABLED,
    LTSSM_LOOPBACK,
    LTSSM_HOT_RESET
  } ltssm_t;

  typedef enum logic [2:0] {
    LINK_DOWN,
    LINK_L0,
    LINK_L1_REQ,
    LINK_L1_ACK,
    LINK_L1,
    LINK_L23_READY
  } link_state_t;

endpackage : aspm_pkg

// ---- rtl/persist_if.sv ----
// carrier between a port controller and its persistence timer
`timescale 1ns/1ps
interface persist_if;
  logic run;
  logic done;
  modport timer (input run, output done);
  modport user (output run, input done);
endinterface : persist_if

// ---- rtl/persist_timer.sv ----
// persistence timer: done once run has held for count cycles
`timescale 1ns/1ps
module persist_timer #(
  parameter int COUNT = 70
) (
  input wire logic clk,
  input wire logic arst_n,
  persist_if.timer tmr
);

  localparam int W = $clog2(COUNT + 1);

  initial begin
    if (COUNT < 1) begin
      $error("persist_timer: COUNT must be at least 1");
    end
  end

  logic [W-1:0] count;

  // ****************************************************************
  // count while held, restart on any drop
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!tmr.run) begin
      count <= '0;
    end else if (count != W'(COUNT)) begin
      count <= count + W'(1);
    end
  end

  assign tmr.done = tmr.run && (count == W'(COUNT));

endmodule : persist_timer

// ---- rtl/aspm_partition_ctrl.sv ----
// active state link power control for the ports of one switch partition
`timescale 1ns/1ps
module aspm_partition_ctrl #(
  parameter int NUM_DSP = 3,
  parameter int L0S_PERSIST_CYCLES = aspm_pkg::L0S_PERSIST_CYC,
  parameter int L1_PERSIST_CYCLES = aspm_pkg::L1_PERSIST_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [aspm_pkg::ASPM_W-1:0] link_control_reg [NUM_DSP+1],
  input aspm_pkg::ltssm_t ltssm_state [NUM_DSP+1],
  input wire logic [NUM_DSP:0] function_sleep_state,
  input wire logic [NUM_DSP:0] tlp_pending,
  input wire logic [NUM_DSP:0] tlp_scheduled,
  input wire logic [NUM_DSP:0] dllp_pending,
  input wire logic [NUM_DSP:0] dllp_scheduled,
  input wire logic [NUM_DSP:0] ack_nak_pending,
  input wire logic [NUM_DSP:0] fc_credit_avail,
  input wire logic usp_max_credits,
  input wire logic usp_replay_empty,
  input wire logic usp_rx_idle,
  input wire logic [NUM_DSP:0] rx_l0s_entry,
  input wire logic [NUM_DSP:0] rx_l0s_exit,
  input wire logic usp_l1_ack_rx,
  input wire logic usp_l1_nak_rx,
  input wire logic [NUM_DSP:0] partner_l1_req,
  input wire logic [NUM_DSP:0] partner_eidle,
  input wire logic [NUM_DSP:0] turn_off_acked,
  output aspm_pkg::link_state_t link_state [NUM_DSP+1],
  output logic [NUM_DSP:0] link_up,
  output logic [NUM_DSP:0] tx_l0s,
  output logic [NUM_DSP:0] rx_l0s,
  output logic [NUM_DSP:0] tx_l0s_leave,
  output logic [NUM_DSP:0] l1_leave,
  output logic [NUM_DSP:0] send_pm_ack,
  output logic [NUM_DSP:0] send_aspm_nak,
  output logic [NUM_DSP:0] traffic_hold
);

  localparam int NP = NUM_DSP + 1;
  localparam int USP = 0;

  initial begin
    if (NUM_DSP < 1) begin
      $error("aspm_partition_ctrl: NUM_DSP must be at least 1");
    end
    if (L0S_PERSIST_CYCLES < 1 || L1_PERSIST_CYCLES < 1) begin
      $error("aspm_partition_ctrl: persistence counts must be at least 1");
    end
  end

  // ****************************************************************
  // decoders
  // ****************************************************************
  function automatic logic is_link_down(input aspm_pkg::ltssm_t st);
    case (st)
      aspm_pkg::LTSSM_DETECT,
      aspm_pkg::LTSSM_POLLING,
      aspm_pkg::LTSSM_CONFIG,
      aspm_pkg::LTSSM_DISABLED,
      aspm_pkg::LTSSM_LOOPBACK,
      aspm_pkg::LTSSM_HOT_RESET: is_link_down = 1'b1;
      default: is_link_down = 1'b0;
    endcase
  endfunction : is_link_down

  function automatic logic is_active_state(input aspm_pkg::link_state_t st);
    is_active_state = (st == aspm_pkg::LINK_L0);
  endfunction : is_active_state

  // ****************************************************************
  // partition wide terms
  // ****************************************************************
  logic [NP-1:0] down;
  logic [NP-1:0] en_l0s;
  logic [NP-1:0] en_l1;
  logic [NP-1:0] dsp_quiet_l0s;
  logic [NP-1:0] dsp_quiet_l1;
  logic all_dsp_rx_l0s;
  logic all_dsp_l1;
  logic any_dsp_l0s_leave;
  logic any_dsp_l1_leave;
  logic [NP-1:0] l0s_cond;
  logic [NP-1:0] l0s_go;
  logic [NP-1:0] l0s_exit;
  logic [NP-1:0] l1_exit;
  logic usp_l1_cond;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_dec
      assign down[gi] = is_link_down(ltssm_state[gi]);
      assign en_l0s[gi] = link_control_reg[gi][aspm_pkg::ASPM_L0S_BIT];
      assign en_l1[gi] = link_control_reg[gi][aspm_pkg::ASPM_L1_BIT];
      if (gi == USP) begin : g_u
        assign dsp_quiet_l0s[gi] = 1'b1;
        assign dsp_quiet_l1[gi] = 1'b1;
      end else begin : g_d
        // sleeping or down downstream ports are left out
        assign dsp_quiet_l0s[gi] = function_sleep_state[gi] || down[gi] || rx_l0s[gi];
        assign dsp_quiet_l1[gi] = function_sleep_state[gi] || down[gi] ||
                                  (link_state[gi] == aspm_pkg::LINK_L1);
      end
    end
  endgenerate

  assign all_dsp_rx_l0s = &dsp_quiet_l0s;
  assign all_dsp_l1 = &dsp_quiet_l1;
  assign any_dsp_l0s_leave = |tx_l0s_leave[NP-1:1];
  assign any_dsp_l1_leave = |l1_leave[NP-1:1];

  // ****************************************************************
  // transmit L0s entry and exit terms and L1 exit terms
  // ****************************************************************
  generate
    for (gi = 0; gi < NP; gi++) begin : g_l0s
      logic idle_tx;
      assign idle_tx = (!tlp_pending[gi] || !fc_credit_avail[gi]) && !dllp_pending[gi];
      if (gi == USP) begin : g_u
        assign l0s_cond[gi] = en_l0s[gi] && all_dsp_rx_l0s && idle_tx &&
                              is_active_state(link_state[gi]) && !tx_l0s[gi];
        assign l0s_exit[gi] = tlp_scheduled[gi] || dllp_scheduled[gi] ||
                              any_dsp_l0s_leave;
        assign l1_exit[gi] = tlp_scheduled[gi] || any_dsp_l1_leave;
      end else begin : g_d
        assign l0s_cond[gi] = en_l0s[gi] && rx_l0s[USP] && idle_tx &&
                              is_active_state(link_state[gi]) && !tx_l0s[gi];
        assign l0s_exit[gi] = tlp_scheduled[gi] || dllp_scheduled[gi] ||
                              tx_l0s_leave[USP];
        assign l1_exit[gi] = tlp_scheduled[gi] || l1_leave[USP];
      end

      persist_if l0s_tmr ();
      assign l0s_tmr.run = l0s_cond[gi];
      assign l0s_go[gi] = l0s_tmr.done;
      persist_timer #(
        .COUNT(L0S_PERSIST_CYCLES)
      ) u_l0s_timer (
        .clk(clk),
        .arst_n(arst_n),
        .tmr(l0s_tmr)
      );
    end
  endgenerate

  // ****************************************************************
  // upstream L1 request persistence
  // ****************************************************************
  logic usp_l1_go;
  persist_if l1_tmr ();

  assign usp_l1_cond = en_l1[USP] && all_dsp_l1 && !tlp_pending[USP] &&
                       usp_replay_empty && !dllp_pending[USP] && usp_rx_idle &&
                       usp_max_credits &&
                       is_active_state(link_state[USP]);
  assign l1_tmr.run = usp_l1_cond;
  assign usp_l1_go = l1_tmr.done;

  persist_timer #(
    .COUNT(L1_PERSIST_CYCLES)
  ) u_l1_timer (
    .clk(clk),
    .arst_n(arst_n),
    .tmr(l1_tmr)
  );

  // ****************************************************************
  // receive L0s follows the partner
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_l0s <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (down[i] || rx_l0s_exit[i]) begin
          rx_l0s[i] <= 1'b0;
        end else if (rx_l0s_entry[i]) begin
          rx_l0s[i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // transmit L0s state
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_l0s <= '0;
      tx_l0s_leave <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        tx_l0s_leave[i] <= 1'b0;
        if (down[i] || !is_active_state(link_state[i])) begin
          tx_l0s[i] <= 1'b0;
        end else if (tx_l0s[i] && l0s_exit[i]) begin
          tx_l0s[i] <= 1'b0;
          tx_l0s_leave[i] <= 1'b1;
        end else if (l0s_go[i]) begin
          tx_l0s[i] <= 1'b1;
        end
      end
      if (link_state[USP] == aspm_pkg::LINK_L1_REQ && usp_l1_nak_rx && en_l0s[USP]) begin
        tx_l0s[USP] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // link power state per port, upstream port forced to request L1 while its function sleeps and held in L1 once acked until it wakes or a turn off is acked
  // ****************************************************************
  logic [NP-1:0] nak_done;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NP; i++) begin
        link_state[i] <= aspm_pkg::LINK_DOWN;
      end
      l1_leave <= '0;
      send_pm_ack <= '0;
      send_aspm_nak <= '0;
      nak_done <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        l1_leave[i] <= 1'b0;
        send_aspm_nak[i] <= 1'b0;
        if (!partner_l1_req[i]) begin
          nak_done[i] <= 1'b0;
        end
        if (down[i]) begin
          link_state[i] <= aspm_pkg::LINK_DOWN;
          send_pm_ack[i] <= 1'b0;
        end else begin
          case (link_state[i])
            aspm_pkg::LINK_DOWN: begin
              link_state[i] <= aspm_pkg::LINK_L0;
            end
            aspm_pkg::LINK_L0: begin
              if (turn_off_acked[i]) begin
                link_state[i] <= aspm_pkg::LINK_L23_READY;
              end else if (i == USP) begin
                if (usp_l1_go || function_sleep_state[USP]) begin
                  link_state[i] <= aspm_pkg::LINK_L1_REQ;
                end
              end else if (partner_l1_req[i] && !nak_done[i]) begin
                if (en_l1[i] && !tlp_pending[i] && !ack_nak_pending[i]) begin
                  link_state[i] <= aspm_pkg::LINK_L1_ACK;
                  send_pm_ack[i] <= 1'b1;
                end else begin
                  send_aspm_nak[i] <= 1'b1;
                  nak_done[i] <= 1'b1;
                end
              end
            end
            aspm_pkg::LINK_L1_REQ: begin
              if (usp_l1_ack_rx) begin
                link_state[i] <= aspm_pkg::LINK_L1;
              end else if (usp_l1_nak_rx) begin
                link_state[i] <= aspm_pkg::LINK_L0;
              end
            end
            aspm_pkg::LINK_L1_ACK: begin
              if (partner_eidle[i]) begin
                link_state[i] <= aspm_pkg::LINK_L1;
                send_pm_ack[i] <= 1'b0;
              end
            end
            aspm_pkg::LINK_L1: begin
              if (turn_off_acked[i]) begin
                link_state[i] <= aspm_pkg::LINK_L23_READY;
              end else if (l1_exit[i] && !(i == USP && function_sleep_state[USP])) begin
                link_state[i] <= aspm_pkg::LINK_L0;
                l1_leave[i] <= 1'b1;
              end
            end
            aspm_pkg::LINK_L23_READY: begin
              link_state[i] <= aspm_pkg::LINK_L23_READY;
            end
            default: begin
              link_state[i] <= aspm_pkg::LINK_DOWN;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // link up and traffic hold flags
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_up <= '0;
      traffic_hold <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        link_up[i] <= !down[i];
        traffic_hold[i] <= !down[i] && (link_state[i] == aspm_pkg::LINK_L23_READY);
      end
    end
  end

endmodule : aspm_partition_ctrl

// ---- dv/aspm_checker.sv ----
// concurrent checks on the ports of the partition power control
`timescale 1ns/1ps
module aspm_checker #(
  parameter int NUM_DSP = 3,
  parameter int L0S_PERSIST_CYCLES = 70
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [aspm_pkg::ASPM_W-1:0] link_control_reg [NUM_DSP+1],
  input aspm_pkg::ltssm_t ltssm_state [NUM_DSP+1],
  input wire logic [NUM_DSP:0] tlp_pending,
  input wire logic [NUM_DSP:0] dllp_pending,
  input wire logic [NUM_DSP:0] ack_nak_pending,
  input wire logic [NUM_DSP:0] fc_credit_avail,
  input wire logic usp_l1_ack_rx,
  input wire logic [NUM_DSP:0] partner_l1_req,
  input wire logic [NUM_DSP:0] partner_eidle,
  input aspm_pkg::link_state_t link_state [NUM_DSP+1],
  input wire logic [NUM_DSP:0] link_up,
  input wire logic [NUM_DSP:0] tx_l0s,
  input wire logic [NUM_DSP:0] rx_l0s,
  input wire logic [NUM_DSP:0] tx_l0s_leave,
  input wire logic [NUM_DSP:0] l1_leave,
  input wire logic [NUM_DSP:0] send_pm_ack,
  input wire logic [NUM_DSP:0] send_aspm_nak
);
  // ****************************************************************
  // helpers: acceptance and persistence of the first downstream port
  // ****************************************************************
  logic l1_ok;
  logic l0s_ok;
  int unsigned run_cnt;
  assign l1_ok = link_control_reg[1][aspm_pkg::ASPM_L1_BIT] && !tlp_pending[1]
    && !ack_nak_pending[1];
  assign l0s_ok = link_control_reg[1][aspm_pkg::ASPM_L0S_BIT] && rx_l0s[0] && !dllp_pending[1]
    && (!tlp_pending[1] || !fc_credit_avail[1]) && link_state[1] == aspm_pkg::LINK_L0;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= l0s_ok ? run_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_l1_ask;
    link_state[1] == aspm_pkg::LINK_L0 && partner_l1_req[1];
  endsequence
  sequence s_nak_once;
    send_aspm_nak[1] ##1 !send_aspm_nak[1];
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_dsp_accept: assert property (s_l1_ask ##0 l1_ok
    |=> link_state[1] == aspm_pkg::LINK_L1_ACK && send_pm_ack[1]) else $error("accept missing");
  a_dsp_reject: assert property (s_l1_ask ##0 (!l1_ok && !$past(partner_l1_req[1]))
    |=> s_nak_once) else $error("reject nak wrong");
  a_ack_till_idle: assert property (send_pm_ack[1] && !partner_eidle[1]
    |=> send_pm_ack[1]) else $error("ack dropped early");
  a_idle_ends_ack: assert property (link_state[1] == aspm_pkg::LINK_L1_ACK && partner_eidle[1]
    |=> link_state[1] == aspm_pkg::LINK_L1 && !send_pm_ack[1]) else $error("idle did not end ack");
  a_tx_l0s_wait: assert property ($rose(tx_l0s[1])
    |-> run_cnt >= L0S_PERSIST_CYCLES + 1) else $error("tx l0s entered early");
  a_usp_l0s_exit: assert property (tx_l0s[0] && tx_l0s_leave[1]
    |-> ##[0:2] tx_l0s_leave[0]) else $error("usp l0s exit missing");
  a_dsp_l1_exit: assert property (l1_leave[0] && link_state[1] == aspm_pkg::LINK_L1
    |-> ##[0:10] l1_leave[1]) else $error("dsp l1 exit late");
  a_usp_l1_ack: assert property (link_state[0] == aspm_pkg::LINK_L1_REQ && usp_l1_ack_rx
    |=> link_state[0] == aspm_pkg::LINK_L1) else $error("usp l1 not entered");
  a_link_down: assert property (!(ltssm_state[1] inside {aspm_pkg::LTSSM_L0,
    aspm_pkg::LTSSM_RECOVERY}) |=> !link_up[1] && link_state[1] == aspm_pkg::LINK_DOWN)
    else $error("link down not shown");
endmodule : aspm_checker

bind aspm_partition_ctrl aspm_checker #(.NUM_DSP(NUM_DSP),
  .L0S_PERSIST_CYCLES(L0S_PERSIST_CYCLES)) aspm_checker_i (.clk(clk), .arst_n(arst_n),
  .link_control_reg(link_control_reg), .ltssm_state(ltssm_state), .tlp_pending(tlp_pending),
  .dllp_pending(dllp_pending), .ack_nak_pending(ack_nak_pending),
  .fc_credit_avail(fc_credit_avail), .usp_l1_ack_rx(usp_l1_ack_rx),
  .partner_l1_req(partner_l1_req), .partner_eidle(partner_eidle), .link_state(link_state),
  .link_up(link_up), .tx_l0s(tx_l0s), .rx_l0s(rx_l0s), .tx_l0s_leave(tx_l0s_leave),
  .l1_leave(l1_leave), .send_pm_ack(send_pm_ack), .send_aspm_nak(send_aspm_nak));

// ---- dv/link_partner.sv ----
// link partner: answers the switch power handshakes after a set delay
`timescale 1ns/1ps
module link_partner (
  input wire logic clk,
  input wire logic ack_seen,
  input wire logic l1_asked,
  input wire logic refuse,
  input wire logic [3:0] delay,
  output logic eidle,
  output logic l1_ack,
  output logic l1_nak
);
  logic [3:0] wait_cnt = 4'h0;
  initial begin
    eidle = 1'b0;
    l1_ack = 1'b0;
    l1_nak = 1'b0;
  end
  // one-cycle answers launched off the falling edge
  always @(negedge clk) begin
    eidle <= ack_seen && wait_cnt == delay;
    l1_ack <= l1_asked && !refuse && wait_cnt == delay;
    l1_nak <= l1_asked && refuse && wait_cnt == delay;
    wait_cnt <= (ack_seen || l1_asked) ? wait_cnt + {3'h0, wait_cnt != 4'hF} : 4'h0;
  end
endmodule : link_partner

// ---- dv/tb.sv ----
// self-checking bench for the partition power control
`timescale 1ns/1ps
module tb;
  localparam int L0S = 4;
  localparam int L1P = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] ctl [2];
  aspm_pkg::ltssm_t lt [2];
  aspm_pkg::link_state_t ls [2];
  logic [1:0] sleep, tlp_p, tlp_s, dllp_p, dllp_s, ackn, fc, rx_in, rx_out, l1req, toff;
  logic [1:0] up, txs, rxs, txlv, l1lv, pmack, nak, hold;
  logic maxc, repl, rxidle, uack, unak, refuse, eid1;
  logic [3:0] dly;
  wire [1:0] eidle = {eid1, 1'b0};
  int fail_count = 0;
  int checks = 0;
  always #50 clk = ~clk;
  aspm_partition_ctrl #(.NUM_DSP(1), .L0S_PERSIST_CYCLES(L0S), .L1_PERSIST_CYCLES(L1P))
    aspm_partition_ctrl_i (.clk(clk), .arst_n(arst_n), .link_control_reg(ctl),
    .ltssm_state(lt), .function_sleep_state(sleep), .tlp_pending(tlp_p), .tlp_scheduled(tlp_s),
    .dllp_pending(dllp_p), .dllp_scheduled(dllp_s), .ack_nak_pending(ackn),
    .fc_credit_avail(fc), .usp_max_credits(maxc), .usp_replay_empty(repl),
    .usp_rx_idle(rxidle), .rx_l0s_entry(rx_in), .rx_l0s_exit(rx_out), .usp_l1_ack_rx(uack),
    .usp_l1_nak_rx(unak), .partner_l1_req(l1req), .partner_eidle(eidle),
    .turn_off_acked(toff), .link_state(ls), .link_up(up), .tx_l0s(txs), .rx_l0s(rxs),
    .tx_l0s_leave(txlv), .l1_leave(l1lv), .send_pm_ack(pmack), .send_aspm_nak(nak),
    .traffic_hold(hold));
  link_partner link_partner_i (.clk(clk), .ack_seen(pmack[1]),
    .l1_asked(ls[0] == aspm_pkg::LINK_L1_REQ), .refuse(refuse), .delay(dly),
    .eidle(eid1), .l1_ack(uack), .l1_nak(unak));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic link_is_up(input aspm_pkg::ltssm_t s);
    return s == aspm_pkg::LTSSM_L0 || s == aspm_pkg::LTSSM_RECOVERY;
  endfunction : link_is_up
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic wait_ls(input int p, input aspm_pkg::link_state_t st, input int lim);
    for (int i = 0; i < lim && ls[p] !== st; i++) @(negedge clk);
    check("link state", ls[p], st);
    if (ls[p] !== st) end_of_test();
  endtask : wait_ls
  task automatic dsp_l1(input int i);
    ctl[1] = {i[0], 1'b0};
    tlp_p[1] = i[1];
    ackn = {2{i[2]}};
    dly = 4'($urandom_range(5, 0));
    step(1);
    l1req[1] = 1'b1;
    step(1);
    if (i == 1) begin
      check("l1 accept", {pmack[1], ls[1]}, {1'b1, aspm_pkg::LINK_L1_ACK});
      wait_ls(1, aspm_pkg::LINK_L1, 20);
      check("ack stops", pmack[1], 1'b0);
    end else begin
      check("l1 reject", nak[1], 1'b1);
      step(1);
      check("single nak", {nak[1], ls[1]}, {1'b0, aspm_pkg::LINK_L0});
    end
    {l1req[1], tlp_p[1]} = 2'h0;
    ackn = 2'h0;
    step(100);
  endtask : dsp_l1
  task automatic usp_l1(input logic rf);
    logic [4:0] bad;
    bad = 5'h1 << $urandom_range(4, 0);
    refuse = rf;
    dly = 4'($urandom_range(5, 0));
    ctl[0] = 2'h3;
    {maxc, repl, rxidle, tlp_p[0], dllp_p[0]} = bad ^ 5'h1C;
    step(L1P + 5);
    check("l1 blocked", ls[0], aspm_pkg::LINK_L0);
    {maxc, repl, rxidle, tlp_p[0], dllp_p[0]} = 5'h1C;
    step(L1P);
    check("l1 wait", ls[0], aspm_pkg::LINK_L0);
    step(1);
    check("l1 request", ls[0], aspm_pkg::LINK_L1_REQ);
    if (rf) begin
      wait_ls(0, aspm_pkg::LINK_L0, 10);
      step(1);
      check("l0s after nak", txs[0], 1'b1);
      refuse = 1'b0;
    end
    wait_ls(0, aspm_pkg::LINK_L1, L1P + 20);
  endtask : usp_l1
  task automatic leave_l1(input int p, input logic both);
    tlp_s[p] = 1'b1;
    step(1);
    tlp_s[p] = 1'b0;
    check("l1 leave", {l1lv[p], ls[p]}, {1'b1, aspm_pkg::LINK_L0});
    step(1);
    check("l1 follow", l1lv[1 - p], both);
  endtask : leave_l1
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h6A8C));
    ctl[0] = 2'h0;
    ctl[1] = 2'h0;
    lt[0] = aspm_pkg::LTSSM_DETECT;
    lt[1] = aspm_pkg::LTSSM_DETECT;
    {sleep, tlp_p, tlp_s, dllp_p, dllp_s, ackn, rx_in, rx_out, l1req, toff} = '0;
    fc = 2'h3;
    {maxc, repl, rxidle, refuse, dly} = 8'h60;
    step(4);
    check("reset state", {up, ls[1]}, {2'h0, aspm_pkg::LINK_DOWN});
    step(1);
    arst_n = 1'b1;
    lt[0] = aspm_pkg::LTSSM_L0;
    lt[1] = aspm_pkg::LTSSM_L0;
    step(3);
    check("link up", {up, ls[0], ls[1]}, {2'h3, aspm_pkg::LINK_L0, aspm_pkg::LINK_L0});
    rx_in = 2'h3;
    step(1);
    rx_in = 2'h0;
    check("rx l0s", {rxs, txs}, 4'hC);
    $display("test rx l0s done");
    {tlp_p[1], fc[1]} = 2'h2;
    ctl[1] = 2'h1;
    repeat (6) begin
      step(1 + $urandom_range(L0S - 1, 0));
      dllp_p[1] = 1'b1;
      step(1);
      dllp_p[1] = 1'b0;
      check("early l0s", txs[1], 1'b0);
    end
    step(L0S);
    check("l0s wait", txs[1], 1'b0);
    step(1);
    check("l0s entry", txs[1], 1'b1);
    $display("test dsp tx l0s done");
    {tlp_p[1], fc[1]} = 2'h1;
    ctl[0] = 2'h1;
    step(L0S + 2);
    check("usp l0s", txs[0], 1'b1);
    dllp_s[1] = 1'b1;
    step(1);
    dllp_s[1] = 1'b0;
    check("dsp l0s leave", txlv[1], 1'b1);
    step(1);
    check("usp l0s leave", txlv[0], 1'b1);
    $display("test tx l0s exit done");
    for (int i = 0; i < 8; i++) begin
      dsp_l1(i);
      if (i == 1) leave_l1(1, 1'b0);
    end
    $display("test dsp l1 done");
    dsp_l1(1);
    usp_l1(1'b1);
    leave_l1(1, 1'b1);
    maxc = 1'b0;
    dsp_l1(1);
    usp_l1(1'b0);
    leave_l1(0, 1'b1);
    $display("test usp l1 done");
    maxc = 1'b0;
    sleep[0] = 1'b1;
    wait_ls(0, aspm_pkg::LINK_L1, 12);
    sleep[0] = 1'b0;
    leave_l1(0, 1'b0);
    $display("test sleep l1 done");
    rx_out = 2'h3;
    step(1);
    rx_out = 2'h0;
    check("rx l0s exit", rxs, 2'h0);
    toff = 2'h3;
    step(1);
    toff = 2'h0;
    check("l23 ready", {hold, up, ls[1]}, {4'h3, aspm_pkg::LINK_L23_READY});
    step(1);
    check("l23 hold", {hold, up, ls[0]}, {4'hF, aspm_pkg::LINK_L23_READY});
    for (int c = 0; c < 8; c++) begin
      lt[1] = aspm_pkg::ltssm_t'(c);
      step(2);
      check("link up flag", up[1], link_is_up(lt[1]));
    end
    $display("test link down done");
    end_of_test();
  end
endmodule : tb
